// File: qsas_pkg.sv
// Shared constants and types for the quad serial adder/subtractor
`default_nettype none
package qsas_pkg;

  // Channel count and buffer shape
  localparam int CHANNELS = 4;
  localparam int FIFO_DEPTH = 16;
  // Entries kept free to absorb bits still in the input pipeline
  localparam int SKID_SLOTS = 4;

  // Operation select encodings
  localparam logic MODE_ADD = 1'h0;
  localparam logic MODE_SUB = 1'h1;

  // Values loaded by a clear
  localparam logic SUM_CLEAR = 1'h0;
  localparam logic CARRY_ADD_PRESET = 1'h0;
  localparam logic CARRY_SUB_PRESET = 1'h1;

  // Reset values of control flags
  localparam logic FLAG_RESET = 1'h0;

  // One bit per channel
  typedef logic [CHANNELS-1:0] lane_t;

  // Operand pins as sampled from outside
  typedef struct packed {
    lane_t a;
    lane_t b;
    lane_t sub;
    logic clear_n;
    logic valid;
  } operand_pins_t;

  // One buffered result slice
  typedef struct packed {
    logic first;
    lane_t bits;
  } result_word_t;

  localparam int RESULT_W = $bits(result_word_t);

  // Word phase, Gray coded along clear, armed, run
  typedef enum logic [1:0] {
    ST_CLEAR = 2'h0,
    ST_ARMED = 2'h1,
    ST_RUN = 2'h3
  } phase_t;

endpackage
`default_nettype wire

// File: serial_word_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module serial_word_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [$clog2(DEPTH+1)-1:0] fill_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage flops
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] wr_ptr; // Write index
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] rd_ptr; // Read index
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] count; // Entries held
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // Handshakes with honest full and empty
  assign wr_ready_out = (count != CW'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign fill_out = count;
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  // Next pointers, count and storage
  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = wr_data_in;
      next_wr_ptr = wr_ptr + 1'h1;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 1'h1;
    end
    if (push && !pop) begin
      next_count = count + 1'h1;
    end else if (pop && !push) begin
      next_count = count - 1'h1;
    end
  end

  // Register stage, frozen while the enable is low
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (ce_in) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      mem <= next_mem;
    end
  end
endmodule // serial_word_fifo
`default_nettype wire

// File: quad_serial_add_subtract.sv
`timescale 1ns/10ps
`default_nettype none
module quad_serial_add_subtract (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire qsas_pkg::operand_pins_t pins_in,
  input wire logic result_ready_in,
  output logic operand_ready_out,
  output qsas_pkg::lane_t sum_bits_out,
  output qsas_pkg::lane_t carry_bits_out,
  output qsas_pkg::lane_t result_bits_out,
  output logic result_first_out,
  output logic result_valid_out,
  output logic clearing_out,
  output logic overflow_out
);
  import qsas_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  localparam int FILL_W = $clog2(FIFO_DEPTH+1);
  // Highest fill at which new operands are still invited
  localparam logic [FILL_W-1:0] READY_LIMIT = FILL_W'(FIFO_DEPTH - SKID_SLOTS);

  operand_pins_t pins_meta; // First synchroniser stage
  operand_pins_t next_pins_meta;
  operand_pins_t pins_sync; // Second synchroniser stage
  operand_pins_t next_pins_sync;

  lane_t sum_q; // Sum flops, one per channel
  lane_t next_sum_q;
  lane_t carry_q; // Carry flops, one per channel
  lane_t next_carry_q;
  lane_t step_sum; // Full adder sum of this bit
  lane_t step_carry; // Full adder carry out of this bit
  lane_t b_eff; // Second operand, inverted for subtract

  phase_t phase; // Word phase
  phase_t next_phase;

  logic clear_active; // Synchronised clear is asserted
  logic step; // A bit pair is consumed this cycle
  logic drop; // A valid pair met a full buffer
  logic overflow_q; // Sticky drop flag
  logic next_overflow_q;
  logic clearing_q; // Registered clear indication
  logic next_clearing_q;
  logic ready_q; // Registered operand ready
  logic next_ready_q;

  result_word_t push_word; // Slice written into the buffer
  result_word_t fifo_word; // Slice at the buffer head
  logic fifo_wr_ready; // Buffer can take a slice
  logic fifo_rd_valid; // Buffer holds a slice
  logic fifo_pop; // Output stage takes the head
  logic [FILL_W-1:0] fifo_fill; // Buffer fill level

  result_word_t out_word; // Output register
  result_word_t next_out_word;
  logic out_valid; // Output register holds a slice
  logic next_out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  ////////////////////////////////////////////////////////////////////////////

  // Two flops on every pin; only the second stage is read
  always_comb begin
    next_pins_meta = pins_in;
    next_pins_sync = pins_meta;
  end

  // Register both stages
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else if (ce_in) begin
      pins_meta <= next_pins_meta;
      pins_sync <= next_pins_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial arithmetic channels
  ////////////////////////////////////////////////////////////////////////////

  // Shared clear, taken from the synchronised pin
  assign clear_active = !pins_sync.clear_n;

  // A pair is consumed when valid, not clearing and buffer has room
  assign step = pins_sync.valid && !clear_active && fifo_wr_ready;
  // A valid pair that cannot be buffered is lost and flagged
  assign drop = pins_sync.valid && !clear_active && !fifo_wr_ready;

  // Full adder per channel; subtract adds the inverse of B
  always_comb begin
    b_eff = '0;
    step_sum = '0;
    step_carry = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      // Low select adds B, high select adds its inverse
      b_eff[i] = pins_sync.b[i] ^ (pins_sync.sub[i] == MODE_SUB);
      // Preset carry supplies the plus one of the complement
      step_sum[i] = pins_sync.a[i] ^ b_eff[i] ^ carry_q[i];
      // Carry keeps rippling while low bits give no other carry
      step_carry[i] = (pins_sync.a[i] & b_eff[i])
                    | (pins_sync.a[i] & carry_q[i])
                    | (b_eff[i] & carry_q[i]);
    end
  end

  // Next sum and carry: clear first, then a step, else hold
  always_comb begin
    next_sum_q = sum_q;
    next_carry_q = carry_q;
    for (int i = 0; i < CHANNELS; i++) begin
      if (clear_active) begin
        // Sum always zero, whatever the mode
        next_sum_q[i] = SUM_CLEAR;
        // Carry preset follows this channel's select
        if (pins_sync.sub[i] == MODE_SUB) begin
          next_carry_q[i] = CARRY_SUB_PRESET;
        end else begin
          next_carry_q[i] = CARRY_ADD_PRESET;
        end
      end else if (step) begin
        // Register the sum bit and the carry out
        next_sum_q[i] = step_sum[i];
        next_carry_q[i] = step_carry[i];
      end
    end
  end

  // Sum and carry flops, rising edge only
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sum_q <= {CHANNELS{SUM_CLEAR}};
      carry_q <= {CHANNELS{CARRY_ADD_PRESET}};
    end else if (ce_in) begin
      sum_q <= next_sum_q;
      carry_q <= next_carry_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word phase and status
  ////////////////////////////////////////////////////////////////////////////

  // Clear arms a new word; the first step marks its least bit
  always_comb begin
    next_phase = phase;
    unique case (phase)
      ST_CLEAR: begin
        // Leave once clear is released, or on an immediate step
        if (step) begin
          next_phase = ST_RUN;
        end else if (!clear_active) begin
          next_phase = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // Waiting for the first bit of the word
        if (clear_active) begin
          next_phase = ST_CLEAR;
        end else if (step) begin
          next_phase = ST_RUN;
        end
      end
      ST_RUN: begin
        // Bits flow until the next clear
        if (clear_active) begin
          next_phase = ST_CLEAR;
        end
      end
      default: begin
        // Illegal code recovers through clear
        next_phase = ST_CLEAR;
      end
    endcase
  end

  // Status flags; a drop sets overflow, a clear resets it; no drop occurs while clearing
  always_comb begin
    next_overflow_q = overflow_q;
    if (drop) begin
      next_overflow_q = 1'h1;
    end else if (clear_active) begin
      next_overflow_q = FLAG_RESET;
    end
    next_clearing_q = clear_active;
    // Invite operands only while skid room remains
    next_ready_q = (fifo_fill <= READY_LIMIT);
  end

  // Phase and status registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      phase <= ST_CLEAR;
      overflow_q <= FLAG_RESET;
      clearing_q <= FLAG_RESET;
      ready_q <= FLAG_RESET;
    end else if (ce_in) begin
      phase <= next_phase;
      overflow_q <= next_overflow_q;
      clearing_q <= next_clearing_q;
      ready_q <= next_ready_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer
  ////////////////////////////////////////////////////////////////////////////

  // Slice pushed is exactly what the sum flops load
  always_comb begin
    push_word.bits = step_sum;
    push_word.first = (phase != ST_RUN);
  end

  // Sixteen slices between the channels and the consumer
  serial_word_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .wr_valid_in(step),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(push_word),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_pop),
    .rd_data_out(fifo_word),
    .fill_out(fifo_fill)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output register
  ////////////////////////////////////////////////////////////////////////////

  // Take the head when the register is empty or being drained
  assign fifo_pop = fifo_rd_valid && (!out_valid || result_ready_in);

  // Next output slice
  always_comb begin
    next_out_word = out_word;
    next_out_valid = out_valid;
    if (fifo_pop) begin
      next_out_word = fifo_word;
      next_out_valid = 1'h1;
    end else if (result_ready_in) begin
      next_out_valid = 1'h0;
    end
  end

  // Output slice register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      out_word <= '0;
      out_valid <= 1'h0;
    end else if (ce_in) begin
      out_word <= next_out_word;
      out_valid <= next_out_valid;
    end
  end

  // Every output is a flop
  assign sum_bits_out = sum_q;
  assign carry_bits_out = carry_q;
  assign result_bits_out = out_word.bits;
  assign result_first_out = out_word.first;
  assign result_valid_out = out_valid;
  assign operand_ready_out = ready_q;
  assign clearing_out = clearing_q;
  assign overflow_out = overflow_q;

endmodule // quad_serial_add_subtract
`default_nettype wire

// File: qsas_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module qsas_checker (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire qsas_pkg::operand_pins_t pins_in,
  input wire logic result_ready_in,
  input wire logic operand_ready_out,
  input wire qsas_pkg::lane_t sum_bits_out,
  input wire qsas_pkg::lane_t carry_bits_out,
  input wire qsas_pkg::lane_t result_bits_out,
  input wire logic result_first_out,
  input wire logic result_valid_out,
  input wire logic clearing_out,
  input wire logic overflow_out
);
  import qsas_pkg::*;
  operand_pins_t p1, p2, p3; // Pin delay line; p3 lines up with the flop update it caused
  logic r1, r2; // Room in the buffer, delayed alike
  lane_t c1; // Carry before the current edge
  ////////////////////////////////////////////////////////////////////////
  // Delay line matching the input synchroniser
  always_ff @(posedge clock_in) begin
    p1 <= pins_in;
    p2 <= p1;
    p3 <= p2;
    r1 <= operand_ready_out;
    r2 <= r1;
    c1 <= carry_bits_out;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////
  a_result_holds: assert property (result_valid_out && !result_ready_in |=> result_valid_out
    && $stable(result_bits_out) && $stable(result_first_out)) else $error("result slice not held");
  a_clear_sum: assert property (!p3.clear_n |-> sum_bits_out == '0)
    else $error("sum not cleared");
  a_clear_carry: assert property (!p3.clear_n |-> carry_bits_out == p3.sub)
    else $error("carry preset wrong");
  a_step_sum: assert property (p3.valid && p3.clear_n && r2
    |-> sum_bits_out == (p3.a ^ p3.b ^ p3.sub ^ c1)) else $error("serial sum wrong");
  a_step_carry: assert property (p3.valid && p3.clear_n && r2 |-> carry_bits_out ==
    ((p3.a & (p3.b ^ p3.sub)) | ((p3.a | (p3.b ^ p3.sub)) & c1))) else $error("carry out wrong");
  a_idle_holds: assert property (!p3.valid && p3.clear_n
    |-> $stable(sum_bits_out) && $stable(carry_bits_out)) else $error("flops moved without a step");
  a_clear_flag: assert property (!$past(srst_in) |-> clearing_out == !p3.clear_n)
    else $error("clear flag wrong");
  a_reset_clean: assert property ($past(srst_in) |-> !result_valid_out && !overflow_out && sum_bits_out == '0)
    else $error("outputs not reset");
endmodule // qsas_checker
bind quad_serial_add_subtract qsas_checker u_qsas_checker (.clock_in(clock_in), .srst_in(srst_in), .pins_in(pins_in),
  .result_ready_in(result_ready_in), .operand_ready_out(operand_ready_out), .sum_bits_out(sum_bits_out),
  .carry_bits_out(carry_bits_out), .result_bits_out(result_bits_out), .result_first_out(result_first_out),
  .result_valid_out(result_valid_out), .clearing_out(clearing_out), .overflow_out(overflow_out));
`default_nettype wire

// File: serial_result_sink.sv
`timescale 1ns/10ps
`default_nettype none
module serial_result_sink (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic stall_in,
  input wire logic slow_in,
  input wire logic valid_in,
  input wire logic first_in,
  input wire qsas_pkg::lane_t bits_in,
  output logic ready_out,
  output logic [3:0][7:0] word_out,
  output logic [7:0] count_out
);
  import qsas_pkg::*;
  logic phase; // Paces a slow consumer to every other cycle
  assign ready_out = !stall_in && (!slow_in || phase);
  ////////////////////////////////////////////////////////////////////////
  // Takes one slice per handshake, LSB first, restarting on the flagged one
  always @(posedge clock_in) begin
    phase <= srst_in ? 1'h0 : !phase;
    if (srst_in) begin
      count_out <= 8'h00;
    end else if (valid_in && ready_out) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (first_in) begin
          word_out[i] <= {7'h00, bits_in[i]};
        end else if (count_out < 8'h08) begin
          word_out[i][count_out[2:0]] <= bits_in[i];
        end
      end
      count_out <= first_in ? 8'h01 : count_out + 8'h01;
    end
  end
endmodule // serial_result_sink
`default_nettype wire

// File: tb_quad_serial_add_subtract.sv
`timescale 1ns/10ps
`default_nettype none
module tb_quad_serial_add_subtract;
  import qsas_pkg::*;
  logic clock_in = 1'h0;
  logic srst_in = 1'h1;
  operand_pins_t pins = '0; // Clear held low through reset
  logic stall = 1'h0;
  logic slow = 1'h0;
  logic ready, op_ready, first, valid, overflow, clearing;
  lane_t sum_bits, carry_bits, res_bits;
  logic [3:0][7:0] word;
  logic [7:0] count;
  int errors = 0;
  int cmp_count = 0;
  always #2.5 clock_in = !clock_in;
  quad_serial_add_subtract u_quad_serial_add_subtract (.clock_in(clock_in), .srst_in(srst_in), .ce_in(1'h1),
    .pins_in(pins), .result_ready_in(ready), .operand_ready_out(op_ready), .sum_bits_out(sum_bits),
    .carry_bits_out(carry_bits), .result_bits_out(res_bits), .result_first_out(first),
    .result_valid_out(valid), .clearing_out(clearing), .overflow_out(overflow));
  serial_result_sink u_sink (.clock_in(clock_in), .srst_in(srst_in), .stall_in(stall), .slow_in(slow),
    .valid_in(valid), .first_in(first), .bits_in(res_bits), .ready_out(ready), .word_out(word), .count_out(count));
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Clear pulse, then n pairs LSB first, back to back unless honour holds a pair while op_ready is low
  task automatic run_word(input lane_t sub, input logic [3:0][7:0] a, input logic [3:0][7:0] b, input int n,
                          input logic honour);
    pins.clear_n = 1'h0;
    pins.valid = 1'h0;
    pins.sub = sub;
    cyc(2);
    pins.clear_n = 1'h1;
    cyc(2);
    check(sum_bits, {CHANNELS{SUM_CLEAR}});
    check(carry_bits, sub);
    check(clearing, 1'h1);
    for (int k = 0; k < n; k++) begin
      while (honour && !op_ready) cyc(1);
      pins.valid = 1'h1;
      for (int i = 0; i < CHANNELS; i++) begin
        pins.a[i] = a[i][k % 8];
        pins.b[i] = b[i][k % 8];
      end
      cyc(1);
    end
    pins.valid = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Mixed modes per channel, result words read back from the sink
  task automatic word_test(input lane_t sub, input logic [3:0][7:0] a, input logic [3:0][7:0] b, input logic pace);
    slow = pace;
    run_word(sub, a, b, 8, 1'h1);
    for (int t = 0; t < 200 && count != 8'h08; t++) cyc(1);
    check(clearing, 1'h0);
    for (int i = 0; i < CHANNELS; i++) check(word[i], 8'(sub[i] ? a[i] - b[i] : a[i] + b[i]));
    $display("word test done");
  endtask
  // Stalled consumer, buffer overrun, then drain
  task automatic overflow_test();
    stall = 1'h1;
    run_word(4'h0, '0, '1, 24, 1'h0);
    cyc(4);
    check(overflow, 1'h1);
    check(op_ready, 1'h0);
    check(valid, 1'h1);
    stall = 1'h0;
    for (int t = 0; t < 100 && valid; t++) cyc(1);
    cyc(1);
    check(valid, 1'h0);
    check(op_ready, 1'h1);
    $display("overflow test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    #1;
    srst_in = 1'h0;
    word_test(4'h5, {8'hC3, 8'h7F, 8'h80, 8'h01}, {8'h3C, 8'h01, 8'h80, 8'h02}, 1'h0);
    word_test(4'hA, {8'h00, 8'h55, 8'h00, 8'hFF}, {8'h10, 8'hAA, 8'h00, 8'h01}, 1'h1);
    overflow_test();
    results();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock_in);
    errors++;
    results();
  end
endmodule // tb_quad_serial_add_subtract
`default_nettype wire
